// ==== hdl/cpsc_core_perf_ctrl.sv ====
// Core performance-state controller: registers, sequencer, C-state actions.
//
// Implementation choices: the register addresses and the plain strobed port.
`default_nettype none
module cpsc_core_perf_ctrl
  import cpsc_pkg::*;
(
  input  wire logic                                clock,
  input  wire logic                                rst_n,
  input  wire logic                                ce,
  input  wire logic [cpsc_pkg::ADDR_W-1:0]         reg_addr,
  input  wire logic [cpsc_pkg::DATA_W-1:0]         reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic      [cpsc_pkg::DATA_W-1:0]         reg_rdata,
  input  wire logic [cpsc_pkg::PS_W-1:0]           boot_perf_state_select,
  input  wire logic [cpsc_pkg::FREQ_W-1:0]         main_pll_freq_code,
  input  wire logic [cpsc_pkg::NUM_USUB-1:0][cpsc_pkg::VID_W-1:0] usub_vid,
  output logic [cpsc_pkg::NUM_CORES-1:0][cpsc_pkg::FREQ_W-1:0] core_freq,
  output logic [cpsc_pkg::NUM_CORES-1:0][cpsc_pkg::DIV_W-1:0]  core_div,
  output logic [cpsc_pkg::NUM_CORES-1:0][cpsc_pkg::CST_W-1:0]  core_cst_act,
  output logic      [cpsc_pkg::CST_W-1:0]          pkg_cst_act,
  output logic      [cpsc_pkg::VID_W-1:0]          core_supply_vid,
  output logic                                     core_vid_strobe,
  output logic      [cpsc_pkg::VID_W-1:0]          uncore_supply_vid,
  output logic                                     notify_cycle,
  output logic      [cpsc_pkg::CORE_W-1:0]         notify_core,
  output logic      [cpsc_pkg::PS_W-1:0]           notify_state
);
  import cpsc_pkg::*;

  typedef struct packed {
    cpsc_entry_type [NUM_PS-1:0]          tbl;
    logic [NUM_CORES-1:0][PS_W-1:0]       req;
    logic [NUM_CORES-1:0][PS_W-1:0]       cur;
    logic [NUM_CORES-1:0][DIV_W-1:0]      div;
    logic [NUM_CORES-1:0][FREQ_W-1:0]     freq;
    logic [NUM_CORES-1:0][CST_W-1:0]      cst_req;
    logic [NUM_CORES-1:0][CST_W-1:0]      cst_act;
    logic [CST_W-1:0]                     pkg_act;
    logic [PS_W-1:0]                      limit;
    logic [PS_W-1:0]                      maxv;
    logic [PS_W-1:0]                      boot;
    logic                                 notify_en;
    logic [RAMP_W-1:0]                    ramp;
    logic [VID_W-1:0]                     usw;
    cpsc_state_type                       st;
    logic [CORE_W-1:0]                    sel;
    logic [PS_W-1:0]                      tgt;
    logic                                 up;
    logic [VID_W-1:0]                     vid;
    logic                                 vid_req;
    logic                                 notify;
    logic [CORE_W-1:0]                    ncore;
    logic [PS_W-1:0]                      nstate;
    logic [DATA_W-1:0]                    rdata;
  } cpsc_ctrl_type;

  cpsc_ctrl_type                    s_q, s_d;
  logic [NUM_CORES-1:0][PS_W-1:0]   clamp;
  logic [NUM_CORES-1:0]             want;
  logic [VID_W-1:0]                 uncore_vid;
  cpsc_vid_if                       vif ();

  // Per-core target: the request held between limit and floor, used only
  // when the selected entry is valid.
  for (genvar g = 0; g < NUM_CORES; g++) begin : g_core
    always_comb begin
      clamp[g] = s_q.req[g];
      if (clamp[g] < s_q.limit) begin
        clamp[g] = s_q.limit;
      end
      if (clamp[g] > s_q.maxv) begin
        clamp[g] = s_q.maxv;
      end
      want[g] = (clamp[g] != s_q.cur[g]) && s_q.tbl[clamp[g]].valid;
    end
  end

  // Voltage for a P-state number.
  function automatic logic [VID_W-1:0] vid_of(input cpsc_ctrl_type s,
                                              input logic [PS_W-1:0] p);
    return s.tbl[p].vid;
  endfunction

  // Main next-state process: register port, sequencer, C-state actions.
  always_comb begin
    logic [PS_W-1:0]   best;
    logic [PS_W-1:0]   ps;
    logic [3:0]        nvalid;
    logic              found;
    logic [CORE_W-1:0] pick;
    logic              all_idle;
    logic [CST_W-1:0]  shallow;
    best = '1;
    ps = '0;
    nvalid = '0;
    found = 1'b0;
    pick = '0;
    all_idle = 1'b1;
    shallow = '1;
    s_d = s_q;
    s_d.vid_req = 1'b0;
    s_d.notify = 1'b0;
    s_d.rdata = '0;

    // Register writes.
    if (reg_wr) begin
      for (int i = 0; i < NUM_CORES; i++) begin
        if (reg_addr == REG_REQ_BASE + REG_STRIDE * 8'(i)) begin
          s_d.req[i] = reg_wdata[PS_W-1:0];
        end
      end
      if (reg_addr == REG_LIMIT) begin
        s_d.limit = reg_wdata[LIM_LIMIT_LSB +: PS_W];
        s_d.maxv  = reg_wdata[LIM_MAX_LSB +: PS_W];
      end
      if (reg_addr == REG_CFG) begin
        s_d.notify_en = reg_wdata[CFG_NOTIFY];
        s_d.ramp = reg_wdata[CFG_RAMP_LSB +: RAMP_W];
      end
      if (reg_addr == REG_CSTATE) begin
        s_d.cst_req = reg_wdata[NUM_CORES*CST_W-1:0];
      end
      if (reg_addr == REG_USW) begin
        s_d.usw = reg_wdata[VID_W-1:0];
      end
      if (reg_addr == REG_BOOT) begin
        s_d.boot = reg_wdata[PS_W-1:0];
      end
      // Fields are placed one by one: the word layout is sparser than
      // the packed entry, so a whole-word copy would shift the valid bit.
      if ((reg_addr & TABLE_MASK) == REG_TABLE) begin
        s_d.tbl[reg_addr[TBL_IDX_LSB +: PS_W]].valid =
          reg_wdata[ENT_VALID];
        s_d.tbl[reg_addr[TBL_IDX_LSB +: PS_W]].div =
          reg_wdata[ENT_DIV_LSB +: DIV_W];
        s_d.tbl[reg_addr[TBL_IDX_LSB +: PS_W]].vid =
          reg_wdata[ENT_VID_LSB +: VID_W];
      end
    end

    // Register reads, answered in the following cycle.
    if (reg_rd) begin
      for (int i = 0; i < NUM_CORES; i++) begin
        if (reg_addr == REG_REQ_BASE + REG_STRIDE * 8'(i)) begin
          s_d.rdata[PS_W-1:0] = s_q.req[i];
        end
        if (reg_addr == REG_STAT_BASE + REG_STRIDE * 8'(i)) begin
          s_d.rdata[PS_W-1:0] = s_q.cur[i];
        end
      end
      if (reg_addr == REG_LIMIT) begin
        s_d.rdata[LIM_LIMIT_LSB +: PS_W] = s_q.limit;
        s_d.rdata[LIM_MAX_LSB +: PS_W] = s_q.maxv;
      end
      if (reg_addr == REG_CFG) begin
        s_d.rdata[CFG_NOTIFY] = s_q.notify_en;
        s_d.rdata[CFG_CAPABLE] = 1'b1;
        s_d.rdata[CFG_RAMP_LSB +: RAMP_W] = s_q.ramp;
      end
      if (reg_addr == REG_CSTATE) begin
        s_d.rdata[NUM_CORES*CST_W-1:0] = s_q.cst_req;
      end
      if (reg_addr == REG_USW) begin
        s_d.rdata[VID_W-1:0] = s_q.usw;
      end
      if (reg_addr == REG_VIDSTAT) begin
        s_d.rdata[VID_W-1:0] = core_supply_vid;
        s_d.rdata[VS_UNC_LSB +: VID_W] = uncore_vid;
      end
      if (reg_addr == REG_BOOT) begin
        s_d.rdata[PS_W-1:0] = s_q.boot;
      end
      if ((reg_addr & TABLE_MASK) == REG_TABLE) begin
        s_d.rdata[ENT_VALID] =
          s_q.tbl[reg_addr[TBL_IDX_LSB +: PS_W]].valid;
        s_d.rdata[ENT_DIV_LSB +: DIV_W] =
          s_q.tbl[reg_addr[TBL_IDX_LSB +: PS_W]].div;
        s_d.rdata[ENT_VID_LSB +: VID_W] =
          s_q.tbl[reg_addr[TBL_IDX_LSB +: PS_W]].vid;
      end
    end

    // Dynamic changes need at least two valid entries.
    for (int k = 0; k < NUM_PS; k++) begin
      nvalid = nvalid + 4'(s_q.tbl[k].valid);
    end

    // Lowest-numbered core with pending work is served first.
    for (int i = NUM_CORES - 1; i >= 0; i--) begin
      if (want[i]) begin
        found = 1'b1;
        pick = CORE_W'(i);
      end
    end

    // Fastest state among cores, the in-flight core at its target.
    for (int i = 0; i < NUM_CORES; i++) begin
      ps = (CORE_W'(i) == s_q.sel) ? s_q.tgt : s_q.cur[i];
      if (ps < best) begin
        best = ps;
      end
    end

    // Transition sequencer; once left idle it returns only through done or reset.
    case (s_q.st)
      ST_IDLE: begin
        if (found && (nvalid > 4'h1)) begin
          s_d.sel = pick;
          s_d.tgt = clamp[pick];
          s_d.up  = clamp[pick] > s_q.cur[pick];
          s_d.st  = (clamp[pick] > s_q.cur[pick]) ? ST_FREQ : ST_VID;
        end
      end
      ST_FREQ: begin
        s_d.div[s_q.sel] = s_q.tbl[s_q.tgt].div;
        s_d.st = s_q.up ? ST_VID : ST_DONE;
      end
      ST_VID: begin
        if (vid_of(s_q, best) != s_q.vid) begin
          s_d.vid = vid_of(s_q, best);
          s_d.vid_req = 1'b1;
          s_d.st = ST_WAIT;
        end else begin
          s_d.st = s_q.up ? ST_DONE : ST_FREQ;
        end
      end
      ST_WAIT: begin
        if (!vif.busy) begin
          s_d.st = s_q.up ? ST_DONE : ST_FREQ;
        end
      end
      ST_DONE: begin
        s_d.cur[s_q.sel] = s_q.tgt;
        s_d.notify = s_q.notify_en;
        // Core and state hold their last notified values while disabled.
        if (s_q.notify_en) begin
          s_d.ncore = s_q.sel;
          s_d.nstate = s_q.tgt;
        end
        s_d.st = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase

    // Core frequency follows the PLL code and each core's divisor.
    for (int i = 0; i < NUM_CORES; i++) begin
      s_d.freq[i] = main_pll_freq_code >> s_q.div[i];
    end

    // C-state actions: per core always, package only when all are idle.
    for (int i = 0; i < NUM_CORES; i++) begin
      s_d.cst_act[i] = s_q.cst_req[i];
      if (s_q.cst_req[i] == CST_C0) begin
        all_idle = 1'b0;
      end
      if (s_q.cst_req[i] < shallow) begin
        shallow = s_q.cst_req[i];
      end
    end
    s_d.pkg_act = all_idle ? shallow : CST_C0;

    // Synchronous reset: the strap is caught while reset is low, so the
    // boot state is both requested and reported afterwards.
    if (!rst_n) begin
      s_d = '0;
      for (int k = 0; k < NUM_PS; k++) begin
        s_d.tbl[k] = rst_entry(PS_W'(k));
      end
      for (int i = 0; i < NUM_CORES; i++) begin
        s_d.req[i] = boot_perf_state_select;
        s_d.cur[i] = boot_perf_state_select;
        s_d.div[i] = rst_entry(boot_perf_state_select).div;
        s_d.cst_req[i] = CST_C0;
        s_d.cst_act[i] = CST_C0;
      end
      s_d.boot = boot_perf_state_select;
      s_d.vid = rst_entry(boot_perf_state_select).vid;
      s_d.limit = RST_LIMIT;
      s_d.maxv = RST_MAXV;
      s_d.ramp = RST_RAMP;
      s_d.usw = RST_USW;
      s_d.st = ST_IDLE;
    end
  end

  // Reset wins over the clock enable so a frozen block still restarts.
  always_ff @(posedge clock) begin
    if (!rst_n || ce) begin
      s_q <= s_d;
    end
  end

  // Sequencer side of the voltage slammer.
  assign vif.req      = s_q.vid_req;
  assign vif.vid      = s_q.vid;
  assign vif.boot_vid = rst_entry(boot_perf_state_select).vid;

  cpsc_vid_slam u_slam (
    .clock      (clock),
    .rst_n      (rst_n),
    .ce         (ce),
    .ramp_wait  (s_q.ramp),
    .vif        (vif.slam),
    .vid_out    (core_supply_vid),
    .vid_strobe (core_vid_strobe)
  );

  cpsc_uncore_arb u_arb (
    .clock      (clock),
    .rst_n      (rst_n),
    .ce         (ce),
    .sub_vid    (usub_vid),
    .sw_vid     (s_q.usw),
    .uncore_vid (uncore_vid)
  );

  // Outputs straight from flip-flops.
  assign uncore_supply_vid = uncore_vid;
  assign reg_rdata    = s_q.rdata;
  assign core_freq    = s_q.freq;
  assign core_div     = s_q.div;
  assign core_cst_act = s_q.cst_act;
  assign pkg_cst_act  = s_q.pkg_act;
  assign notify_cycle = s_q.notify;
  assign notify_core  = s_q.ncore;
  assign notify_state = s_q.nstate;
endmodule // cpsc_core_perf_ctrl
`default_nettype wire

// ==== hdl/cpsc_pkg.sv ====
// Package with constants and types of the core performance-state controller.
`default_nettype none
package cpsc_pkg;
  localparam int NUM_CORES = 2;
  localparam int CORE_W    = 1;
  localparam int NUM_PS    = 8;
  localparam int PS_W      = 3;
  localparam int VID_W     = 8;
  localparam int DIV_W     = 3;
  localparam int FREQ_W    = 6;
  localparam int CST_W     = 2;
  localparam int RAMP_W    = 8;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int NUM_USUB  = 3;

  // Register byte offsets; per-core registers repeat at REG_STRIDE.
  localparam logic [7:0] REG_REQ_BASE  = 8'h00;
  localparam logic [7:0] REG_STAT_BASE = 8'h08;
  localparam logic [7:0] REG_LIMIT     = 8'h10;
  localparam logic [7:0] REG_CFG       = 8'h14;
  localparam logic [7:0] REG_CSTATE    = 8'h18;
  localparam logic [7:0] REG_USW       = 8'h1C;
  localparam logic [7:0] REG_VIDSTAT   = 8'h20;
  localparam logic [7:0] REG_BOOT      = 8'h24;
  localparam logic [7:0] REG_TABLE     = 8'h40;
  localparam logic [7:0] TABLE_MASK    = 8'hE0;
  localparam logic [7:0] REG_STRIDE    = 8'h04;
  localparam int         TBL_IDX_LSB   = 2;

  // Field positions.
  localparam int LIM_LIMIT_LSB = 0;
  localparam int LIM_MAX_LSB   = 4;
  localparam int CFG_NOTIFY    = 0;
  localparam int CFG_CAPABLE   = 1;
  localparam int CFG_RAMP_LSB  = 8;
  localparam int ENT_VID_LSB   = 0;
  localparam int ENT_DIV_LSB   = 8;
  localparam int ENT_VALID     = 16;
  localparam int VS_UNC_LSB    = 8;

  // Reset values.
  localparam logic [PS_W-1:0]   RST_LIMIT    = 3'h0;
  localparam logic [PS_W-1:0]   RST_MAXV     = 3'h7;
  localparam logic [RAMP_W-1:0] RST_RAMP     = 8'h04;
  localparam logic [VID_W-1:0]  RST_USW      = 8'hFF;
  localparam logic [VID_W-1:0]  RST_VID_BASE = 8'h20;
  localparam logic [VID_W-1:0]  RST_VID_STEP = 8'h08;
  localparam logic [CST_W-1:0]  CST_C0       = 2'h0;

  typedef struct packed {
    logic              valid;
    logic [DIV_W-1:0]  div;
    logic [VID_W-1:0]  vid;
  } cpsc_entry_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_FREQ = 5'b00010,
    ST_VID  = 5'b00100,
    ST_WAIT = 5'b01000,
    ST_DONE = 5'b10000
  } cpsc_state_type;

  // Table entry contents after reset: all valid, slowing with the index.
  function automatic cpsc_entry_type rst_entry(input logic [PS_W-1:0] k);
    cpsc_entry_type e;
    e.valid = 1'b1;
    e.div   = DIV_W'(k);
    e.vid   = RST_VID_BASE + RST_VID_STEP * VID_W'(k);
    return e;
  endfunction
endpackage
`default_nettype wire

// ==== hdl/cpsc_vid_if.sv ====
// Interface between the sequencer and the core supply voltage slammer.
`default_nettype none
interface cpsc_vid_if;
  import cpsc_pkg::*;
  logic             req;
  logic [VID_W-1:0] vid;
  logic [VID_W-1:0] boot_vid;
  logic             busy;
  modport seq  (output req, output vid, output boot_vid, input busy);
  modport slam (input req, input vid, input boot_vid, output busy);
endinterface
`default_nettype wire

// ==== hdl/cpsc_vid_slam.sv ====
// Core supply voltage code register with ramp wait after increases.
`default_nettype none
module cpsc_vid_slam
  import cpsc_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  input  wire logic [RAMP_W-1:0]         ramp_wait,
  cpsc_vid_if.slam                       vif,
  output logic      [VID_W-1:0]          vid_out,
  output logic                           vid_strobe
);
  typedef struct packed {
    logic [VID_W-1:0]  vid;
    logic              strobe;
    logic [RAMP_W-1:0] cnt;
  } cpsc_slam_type;

  cpsc_slam_type s_q, s_d;

  // The new code jumps straight to its target; a lower code is a
  // higher voltage and arms the ramp wait, a higher code does not.
  always_comb begin
    s_d = s_q;
    s_d.strobe = 1'b0;
    if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - RAMP_W'(1);
    end
    if (vif.req) begin
      s_d.vid = vif.vid;
      s_d.strobe = 1'b1;
      if (vif.vid < s_q.vid) begin
        s_d.cnt = ramp_wait;
      end
    end
    if (!rst_n) begin
      s_d = '0;
      s_d.vid = vif.boot_vid;
    end
  end

  // Reset acts even while the clock enable is low.
  always_ff @(posedge clock) begin
    if (!rst_n || ce) begin
      s_q <= s_d;
    end
  end

  assign vif.busy   = vif.req || (s_q.cnt != '0);
  assign vid_out    = s_q.vid;
  assign vid_strobe = s_q.strobe;
endmodule // cpsc_vid_slam
`default_nettype wire

// ==== hdl/cpsc_uncore_arb.sv ====
// Uncore supply voltage arbiter: the lowest code among all requests wins.
`default_nettype none
module cpsc_uncore_arb
  import cpsc_pkg::*;
(
  input  wire logic                           clock,
  input  wire logic                           rst_n,
  input  wire logic                           ce,
  input  wire logic [NUM_USUB-1:0][VID_W-1:0] sub_vid,
  input  wire logic [VID_W-1:0]               sw_vid,
  output logic      [VID_W-1:0]               uncore_vid
);
  typedef struct packed {
    logic [VID_W-1:0] vid;
  } cpsc_arb_type;

  cpsc_arb_type               s_q, s_d;
  logic [NUM_USUB:0][VID_W-1:0] chain;

  // A chain of minimum stages, the software request seeding it.
  assign chain[0] = sw_vid;
  for (genvar g = 0; g < NUM_USUB; g++) begin : g_min
    assign chain[g+1] = (sub_vid[g] < chain[g]) ? sub_vid[g] : chain[g];
  end

  always_comb begin
    s_d.vid = chain[NUM_USUB];
    if (!rst_n) begin
      s_d.vid = RST_USW;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || ce) begin
      s_q <= s_d;
    end
  end

  assign uncore_vid = s_q.vid;
endmodule // cpsc_uncore_arb
`default_nettype wire

// ==== verification/cpsc_props.sv ====
// Port-level assertions for the core performance-state controller.
`default_nettype none
module cpsc_props (
  input wire logic                                      clock,
  input wire logic                                      rst_n,
  input wire logic                                      reg_rd,
  input wire logic [cpsc_pkg::DATA_W-1:0]               reg_rdata,
  input wire logic [cpsc_pkg::FREQ_W-1:0]               main_pll_freq_code,
  input wire logic [2:0][cpsc_pkg::VID_W-1:0]           usub_vid,
  input wire logic [1:0][cpsc_pkg::FREQ_W-1:0]          core_freq,
  input wire logic [1:0][cpsc_pkg::DIV_W-1:0]           core_div,
  input wire logic [1:0][cpsc_pkg::CST_W-1:0]           core_cst_act,
  input wire logic [cpsc_pkg::CST_W-1:0]                pkg_cst_act,
  input wire logic [cpsc_pkg::VID_W-1:0]                core_supply_vid,
  input wire logic                                      core_vid_strobe,
  input wire logic [cpsc_pkg::VID_W-1:0]                uncore_supply_vid,
  input wire logic                                      notify_cycle,
  input wire logic [cpsc_pkg::CORE_W-1:0]               notify_core,
  input wire logic [cpsc_pkg::PS_W-1:0]                 notify_state
);
  timeunit 1ns;
  timeprecision 1ns;
  import cpsc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Frequency is skipped for two edges after reset, while it settles.
  a_freq_own_div: assert property ($past(rst_n, 2) |->
    core_freq[0] == ($past(main_pll_freq_code) >> $past(core_div[0])) &&
    core_freq[1] == ($past(main_pll_freq_code) >> $past(core_div[1])))
    else $error("core frequency does not follow its divisor");
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside the read answer cycle");
  a_pkg_active_c0: assert property ($stable(core_cst_act) &&
    (core_cst_act[0] == CST_C0 || core_cst_act[1] == CST_C0)
    |-> pkg_cst_act == CST_C0)
    else $error("package action taken while a core is active");
  a_pkg_shallowest: assert property ($stable(core_cst_act) &&
    core_cst_act[0] != CST_C0 && core_cst_act[1] != CST_C0 |->
    pkg_cst_act == (core_cst_act[0] < core_cst_act[1] ?
                    core_cst_act[0] : core_cst_act[1]))
    else $error("package action is not the shallowest request");
  a_uncore_lowest: assert property ($past(rst_n) |->
    uncore_supply_vid <= $past(usub_vid[0]) &&
    uncore_supply_vid <= $past(usub_vid[1]) &&
    uncore_supply_vid <= $past(usub_vid[2]))
    else $error("uncore code above a subcomponent request");
  a_notify_hold: assert property (!notify_cycle |->
    $stable(notify_core) && $stable(notify_state))
    else $error("notify fields moved without a notify cycle");
  a_notify_one_pulse: assert property (notify_cycle |=>
    !notify_cycle)
    else $error("notify cycle longer than one clock");
  a_vid_slam_strobe: assert property ($changed(core_supply_vid) |->
    core_vid_strobe || $past(core_vid_strobe))
    else $error("core voltage code changed without a strobe");
  // A lower code is a higher voltage, so the ramp wait must follow it.
  a_ramp_after_up: assert property ($changed(core_supply_vid) &&
    core_supply_vid < $past(core_supply_vid) |->
    ##2 !core_vid_strobe [*2])
    else $error("voltage request sent inside the ramp wait");
endmodule // cpsc_props

bind cpsc_core_perf_ctrl cpsc_props props_u (
  .clock(clock), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .main_pll_freq_code(main_pll_freq_code), .usub_vid(usub_vid),
  .core_freq(core_freq), .core_div(core_div), .core_cst_act(core_cst_act),
  .pkg_cst_act(pkg_cst_act), .core_supply_vid(core_supply_vid),
  .core_vid_strobe(core_vid_strobe), .uncore_supply_vid(uncore_supply_vid),
  .notify_cycle(notify_cycle), .notify_core(notify_core),
  .notify_state(notify_state)
);
`default_nettype wire

// ==== verification/cpsc_vreg_model.sv ====
// Behavioural model of the core supply regulator fed by the controller.
`default_nettype none
module cpsc_vreg_model (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic [cpsc_pkg::VID_W-1:0] vid_code,
  input  wire logic                       vid_strobe,
  output logic      [cpsc_pkg::VID_W-1:0] applied_vid
);
  timeunit 1ns;
  timeprecision 1ns;
  import cpsc_pkg::*;
  // The code is taken whole; a real regulator ramps, but never steps codes.
  always_ff @(posedge clock) begin
    if (!rst_n || vid_strobe) begin
      applied_vid <= vid_code;
    end
  end
endmodule // cpsc_vreg_model
`default_nettype wire

// ==== verification/tb_cpsc_core_perf_ctrl.sv ====
// Self-checking testbench of the core performance-state controller.
`default_nettype none
module tb_cpsc_core_perf_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import cpsc_pkg::*;
  logic clock, rst_n, ce, reg_wr, reg_rd, core_vid_strobe, notify_cycle;
  logic [ADDR_W-1:0]          reg_addr;
  logic [DATA_W-1:0]          reg_wdata, reg_rdata;
  logic [FREQ_W-1:0]          pll;
  logic [NUM_USUB-1:0][VID_W-1:0] usub;
  logic [1:0][FREQ_W-1:0]     core_freq;
  logic [1:0][DIV_W-1:0]      core_div;
  logic [1:0][CST_W-1:0]      core_cst_act;
  logic [CST_W-1:0]           pkg_cst_act;
  logic [VID_W-1:0]           core_supply_vid, uncore_supply_vid, applied;
  logic [CORE_W-1:0]          notify_core;
  logic [PS_W-1:0]            notify_state;
  logic [PS_W-1:0]            boot_sel;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  logic [3:0] cst_val [3] = '{4'h2, 4'h6, 4'hF};
  logic [1:0] pkg_exp [3] = '{2'h0, 2'h1, 2'h3};

  cpsc_core_perf_ctrl dut_u (
    .clock(clock), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .boot_perf_state_select(boot_sel),
    .main_pll_freq_code(pll), .usub_vid(usub), .core_freq(core_freq),
    .core_div(core_div), .core_cst_act(core_cst_act),
    .pkg_cst_act(pkg_cst_act), .core_supply_vid(core_supply_vid),
    .core_vid_strobe(core_vid_strobe), .uncore_supply_vid(uncore_supply_vid),
    .notify_cycle(notify_cycle), .notify_core(notify_core),
    .notify_state(notify_state));
  cpsc_vreg_model vreg_u (.clock(clock), .rst_n(rst_n),
    .vid_code(core_supply_vid), .vid_strobe(core_vid_strobe),
    .applied_vid(applied));

  // Free-running clock; a hang is cut off after a generous cycle budget.
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end

  function automatic logic [31:0] vexp(input int k);
    return 32'(RST_VID_BASE + RST_VID_STEP * VID_W'(k));
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The strobe is dropped and one edge passes, so calls never collide.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  // Polls a core's status until it shows the state or the tries run out.
  task automatic wait_stat(input logic c, input logic [2:0] e);
    logic [31:0] d;
    for (int i = 0; i < 60; i++) begin
      rd(REG_STAT_BASE + (c ? REG_STRIDE : 8'h00), d);
      if (d[2:0] === e) break;
    end
    chk(d, {29'h0, e});
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    boot_sel = 3'h2;
    ce = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pll = 6'h3C;
    usub = {8'h60, 8'h40, 8'h50};
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rchk(REG_REQ_BASE, 32'h2);
    rchk(REG_REQ_BASE + REG_STRIDE, 32'h2);
    rchk(REG_STAT_BASE, 32'h2);
    rchk(REG_BOOT, 32'h2);
    rchk(REG_VIDSTAT, 32'h4000 | vexp(2));
    rchk(REG_LIMIT, 32'h70);
    rchk(REG_CFG, 32'h0402);
    rchk(8'h30, 32'h0);
    for (int k = 0; k < NUM_PS; k++)
      rchk(REG_TABLE + 8'(4 * k), 32'h10000 | (k << 8) | vexp(k));
    // Slow core 0 while core 1 keeps the shared voltage up.
    wr(REG_CFG, 32'h0401);
    wr(REG_REQ_BASE, 32'h3);
    wait_stat(1'b0, 3'h3);
    chk(32'(core_div), 32'h13);
    chk(32'(core_freq), 32'({pll >> 2, pll >> 3}));
    chk(32'({notify_core, notify_state}), 32'h3);
    chk(32'(core_supply_vid), vexp(2));
    // Speed core 1 up: voltage rises before its frequency.
    wr(REG_REQ_BASE + REG_STRIDE, 32'h0);
    wait_stat(1'b1, 3'h0);
    chk(32'(applied), vexp(0));
    chk(32'({notify_core, notify_state}), 32'h8);
    wr(REG_REQ_BASE, 32'h1);
    wr(REG_REQ_BASE, 32'h5);
    wait_stat(1'b0, 3'h5);
    // Floor and limit changes move cores without a new request.
    wr(REG_LIMIT, 32'h40);
    wait_stat(1'b0, 3'h4);
    wr(REG_REQ_BASE, 32'h7);
    repeat (20) @(posedge clock);
    rchk(REG_STAT_BASE, 32'h4);
    wr(REG_LIMIT, 32'h43);
    wait_stat(1'b1, 3'h3);
    chk(32'(core_supply_vid), vexp(3));
    wr(REG_CFG, 32'h0400);
    wr(REG_REQ_BASE + REG_STRIDE, 32'h1);
    wr(REG_LIMIT, 32'h40);
    wait_stat(1'b1, 3'h1);
    chk(32'({notify_core, notify_state}), 32'hB);
    for (int i = 0; i < 3; i++) begin
      wr(REG_CSTATE, 32'(cst_val[i]));
      repeat (3) @(posedge clock);
      chk(32'(core_cst_act), 32'(cst_val[i]));
      chk(32'(pkg_cst_act), 32'(pkg_exp[i]));
    end
    wr(REG_USW, 32'h30);
    repeat (3) @(posedge clock);
    chk(32'(uncore_supply_vid), 32'h30);
    usub[1] <= 8'h20;
    repeat (3) @(posedge clock);
    chk(32'(uncore_supply_vid), 32'h20);
    // A second reset with another strap must restart at that state.
    boot_sel <= 3'h5;
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rchk(REG_REQ_BASE + REG_STRIDE, 32'h5);
    rchk(REG_STAT_BASE, 32'h5);
    rchk(REG_BOOT, 32'h5);
    chk(32'(core_supply_vid), vexp(5));
    chk(32'(applied), vexp(5));
    end_sim();
  end
endmodule // tb_cpsc_core_perf_ctrl
`default_nettype wire
